// *** dv/asr_master_model.sv ***
// model of the external ascii master: sends requests, collects replies
// assumes byte streams on core_clk; bench drives through send() and stall
`timescale 1ns/1ps
module asr_master_model (
	input wire logic core_clk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready
);
	logic stall = 1'b0;
	int replies = 0;
	string cur = "";
	string last = "";
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b1;
	end
	// a stalling consumer is ready only on every other cycle
	always @(negedge core_clk) begin
		tx_ready <= stall ? ~tx_ready : 1'b1;
	end
	always @(posedge core_clk) begin
		if (tx_valid && tx_ready) begin
			if (tx_data == asr_pkg::CH_START) begin
				cur = "";
			end
			cur = $sformatf("%s%c", cur, tx_data);
			if (tx_data == asr_pkg::CH_END) begin
				last = cur;
				cur = "";
				replies++;
			end
		end
	end
	// one byte per edge, back to back; idle data shows a changed value
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge core_clk);
			rx_valid = 1'b1;
			rx_data = s[i];
		end
		@(negedge core_clk);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask : send
endmodule : asr_master_model

// *** dv/test_asr_slave.sv ***
// self-checking bench of the ascii read slave with a six-entry table
// assumes the master model beside it and a table answering var_req
`timescale 1ns/1ps
module test_asr_slave;
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	logic [6:0] station_addr = 7'h0f;
	logic [15:0] var_total = 16'h0006;
	logic rx_valid;
	logic [7:0] rx_data;
	logic var_req;
	logic [15:0] var_idx;
	logic var_ack = 1'b0;
	logic [31:0] var_value = 32'h0000_0000;
	asr_pkg::asr_vtype_type var_type = asr_pkg::T_BOOL;
	logic tx_valid;
	logic [7:0] tx_data;
	logic tx_ready;
	logic pwrup_rate;
	logic busy;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic slow = 1'b0;
	logic pend = 1'b0;
	int dly = 0;
	logic [31:0] tv [6];
	asr_pkg::asr_vtype_type tt [6];

	always #2.5 core_clk = ~core_clk;

	asr_slave #(.NVAR_W(16)) i_dut (.core_clk(core_clk), .srst(srst),
		.station_addr(station_addr), .var_total(var_total), .rx_valid(rx_valid),
		.rx_data(rx_data), .var_req(var_req), .var_idx(var_idx), .var_ack(var_ack),
		.var_value(var_value), .var_type(var_type), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .pwrup_rate(pwrup_rate), .busy(busy));

	asr_master_model i_mst (.core_clk(core_clk), .rx_valid(rx_valid), .rx_data(rx_data),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

	// variable table; slow mode stretches the answer to check the wait
	always @(negedge core_clk) begin
		if (var_ack) begin
			var_ack = 1'b0;
			var_value = ~var_value;
		end
		if (var_req) begin
			pend = 1'b1;
			dly = slow ? 3 : 0;
		end else if (pend && dly > 0) begin
			dly--;
		end else if (pend) begin
			pend = 1'b0;
			var_ack = 1'b1;
			var_value = tv[var_idx];
			var_type = tt[var_idx];
		end
	end

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic stop_test;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string name, input string seen, input string exp);
		cmp_count++;
		if (seen != exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %s seen %s", name, exp, seen);
		end
	endtask : check

	// bounded wait for one whole reply, then compare it
	task automatic run(input string name, input string req, input string exp);
		int n;
		n = i_mst.replies;
		i_mst.send(req);
		for (int i = 0; i < 3000 && i_mst.replies == n; i++) @(negedge core_clk);
		check(name, i_mst.last, exp);
	endtask : run

	task automatic quiet(input string name, input string req);
		int n;
		n = i_mst.replies;
		i_mst.send(req);
		repeat (300) @(negedge core_clk);
		check(name, $sformatf("%0d %b", i_mst.replies - n, busy), "0 0");
	endtask : quiet

	task automatic t_power;
		repeat (20) @(negedge core_clk);
		check("idle", $sformatf("%0d %b", i_mst.replies, busy), "0 0");
		check("pwrup", $sformatf("%b", pwrup_rate), "1");
	endtask : t_power

	task automatic t_example;
		run("example", "^1501R00000002&", "^0115r0000000200054/123&");
		check("pwrup_after", $sformatf("%b", pwrup_rate), "0");
	endtask : t_example

	// negatives, bool, widest unsigned byte, slow table and stalling consumer
	task automatic t_mixed;
		slow = 1'b1;
		i_mst.stall = 1'b1;
		run("mixed", "^1509R00002004&", "^0915r000020040013-128/1/255/-6&");
		slow = 1'b0;
		i_mst.stall = 1'b0;
	endtask : t_mixed

	task automatic t_range;
		run("range_edge", "^1507R00003003&", "^0715r0000300300081/255/-6&");
		run("range_over", "^1507R00004003&", "^0715E000000000000&");
	endtask : t_range

	task automatic t_faulty;
		string bad [3];
		bad = '{"^1507W00000001&", "^1507R0a000001&", "^1507R65536000&"};
		foreach (bad[i]) begin
			run("faulty", bad[i], "^0715E000000000000&");
		end
	endtask : t_faulty

	task automatic t_foreign;
		quiet("foreign", "^1607R00000001&");
		quiet("foreign_bad", "^1607W00000001&");
	endtask : t_foreign

	task automatic t_empty;
		run("empty", "^1507R00003000&", "^0715r000030000000&");
	endtask : t_empty

	task automatic t_restart;
		run("restart", "^15^1507R00001001&", "^0715r000010010003123&");
	endtask : t_restart

	initial begin
		tv = '{32'h0000_0004, 32'h0000_007b, 32'h0000_0080, 32'h0000_0001,
			32'h0000_00ff, 32'hffff_fffa};
		tt = '{asr_pkg::T_UDINT, asr_pkg::T_INT, asr_pkg::T_SINT, asr_pkg::T_BOOL,
			asr_pkg::T_USINT, asr_pkg::T_DINT};
		repeat (6) @(negedge core_clk);
		srst = 1'b0;
		t_power();
		t_example();
		t_mixed();
		t_range();
		t_faulty();
		t_foreign();
		t_empty();
		t_restart();
		stop_test();
	end
endmodule : test_asr_slave

// *** pkg/asr_pkg.sv ***
// shared constants and types of the ascii read slave
// assumes byte-wide character streams on a single core clock
package asr_pkg;
	// frame characters
	localparam logic [7:0] CH_START = 8'h5e;
	localparam logic [7:0] CH_END = 8'h26;
	localparam logic [7:0] CH_SLASH = 8'h2f;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_RD = 8'h52;
	localparam logic [7:0] CH_RD_OK = 8'h72;
	localparam logic [7:0] CH_ERR = 8'h45;
	// request character positions, start mark at 0
	localparam logic [3:0] P_DST = 4'h1;
	localparam logic [3:0] P_SRC = 4'h3;
	localparam logic [3:0] P_FC = 4'h5;
	localparam logic [3:0] P_START = 4'h6;
	localparam logic [3:0] P_START_LAST = 4'ha;
	localparam logic [3:0] P_CNT = 4'hb;
	localparam logic [3:0] P_CNT_LAST = 4'hd;
	localparam logic [3:0] P_END = 4'he;
	// reply header: mark, addresses, function, start, count
	localparam logic [3:0] HDR_LAST = 4'hd;
	localparam logic [3:0] NCH_DIGITS_LAST = 4'h3;
	localparam logic [3:0] POW_LAST = 4'h9;
	localparam logic [14:0] MAX_CHARS = 15'd9999;
	localparam logic [16:0] MAX_START = 17'd65535;
	localparam logic [6:0] ADDR_NONE = 7'h00;
	localparam logic [6:0] ADDR_MAX = 7'd99;
	localparam int FIFO_DEPTH = 8;
	// value types of the output variables
	typedef enum logic [2:0] {
		T_BOOL, T_SINT, T_INT, T_DINT, T_USINT, T_UINT, T_UDINT
	} asr_vtype_type;
endpackage : asr_pkg

// *** src/asr_fifo.sv ***
// small fifo with registered read side
// assumes both sides on core_clk, synchronous active high reset
`timescale 1ns/1ps
module asr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [CW-1:0] cnt_r;
	logic out_valid_r;
	logic [WIDTH-1:0] out_data_r;
	logic wr_en;
	logic rd_en;

	// out stage refills whenever it empties or is taken
	assign in_ready = (cnt_r != CNT_FULL);
	assign wr_en = in_valid && in_ready;
	assign rd_en = (cnt_r != '0) && (!out_valid_r || out_ready);
	assign out_valid = out_valid_r;
	assign out_data = out_data_r;

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (wr_en) begin
				wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
			end
			if (rd_en) begin
				rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
			end
			if (wr_en && !rd_en) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (rd_en && !wr_en) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else if (rd_en) begin
			out_valid_r <= 1'b1;
			out_data_r <= mem_r[rd_ptr_r];
		end else if (out_ready) begin
			out_valid_r <= 1'b0;
		end
	end
endmodule : asr_fifo

// *** src/asr_slave.sv ***
// ascii read slave: parses read requests, builds framed decimal replies
// assumes rx bytes from a uart on core_clk and a variable table answering
// var_req with var_ack, entries already ordered by ascending byte offset
//
// Functional notes
// - request is mark, dest2, src2, R, start5, count3, end mark.
// - caret starts every frame; receiver restarts on it.
// - addresses 01..99; reply swaps destination and source.
// - start field is five digits, 00000 to 65535.
// - count field is three digits, 000 to 999.
// - ampersand ends every frame in both directions.
// - replies only follow a received request, never unsolicited.
// - reply header, four-digit character count, data, end mark.
// - good reply carries lowercase r.
// - faulty request answered with uppercase E.
// - character count includes slashes, excludes ampersand, 0000..9999.
// - values separated by one slash, counted as data.
// - decimal values without leading zeros, variable length.
// - error reply: E, 00000, 000, 0000, no data, end mark.
// - start plus count beyond configured variables is faulty.
// - request indexes count variables from 0, not byte offsets.
// - variables sent in ascending offset order.
// - bool as 1 or 0; integers as signed or unsigned decimal.
// - power-up string always goes out at 9600 baud; pwrup_rate drops once the first reply's end mark enters the tx queue.
`timescale 1ns/1ps
module asr_slave #(
	parameter int NVAR_W = 16
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [6:0] station_addr,
	input wire logic [NVAR_W-1:0] var_total,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic var_req,
	output logic [15:0] var_idx,
	input wire logic var_ack,
	input wire logic [31:0] var_value,
	input wire asr_pkg::asr_vtype_type var_type,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic pwrup_rate,
	output logic busy
);
	typedef enum {
		S_IDLE, S_LEN_REQ, S_LEN_WAIT, S_HDR, S_DAT_REQ, S_DAT_WAIT,
		S_SEP, S_SIGN, S_DIG, S_END
	} asr_state_type;

	function automatic logic is_dig(input logic [7:0] c);
		return (c >= asr_pkg::CH_ZERO) && (c <= asr_pkg::CH_NINE);
	endfunction : is_dig

	function automatic logic [31:0] pow10(input logic [3:0] p);
		logic [31:0] r;
		r = 32'h1;
		for (int k = 0; k < 10; k++) begin
			if (k < int'(p)) r = r * 32'ha;
		end
		return r;
	endfunction : pow10

	// {negative, magnitude} of a raw value by type
	function automatic logic [32:0] mag_of(input logic [31:0] v,
			input asr_pkg::asr_vtype_type t);
		logic [31:0] sx;
		logic neg;
		sx = v;
		neg = 1'b0;
		case (t)
			asr_pkg::T_BOOL: sx = {31'h0, v[0]};
			asr_pkg::T_SINT: sx = {{24{v[7]}}, v[7:0]};
			asr_pkg::T_INT: sx = {{16{v[15]}}, v[15:0]};
			asr_pkg::T_USINT: sx = {24'h0, v[7:0]};
			asr_pkg::T_UINT: sx = {16'h0, v[15:0]};
			default: sx = v;
		endcase
		neg = (t == asr_pkg::T_SINT || t == asr_pkg::T_INT
			|| t == asr_pkg::T_DINT) && sx[31];
		return {neg, neg ? (~sx + 32'h1) : sx};
	endfunction : mag_of

	function automatic logic [3:0] ndig(input logic [31:0] m);
		logic [3:0] n;
		n = 4'h1;
		for (int k = 1; k < 10; k++) begin
			if (m >= pow10(4'(k))) n = 4'(k + 1);
		end
		return n;
	endfunction : ndig

	function automatic logic [16:0] acc10(input logic [16:0] a, input logic [7:0] c);
		return 17'((a << 3) + (a << 1) + {13'h0, c[3:0]});
	endfunction : acc10

	asr_state_type state_r;
	logic [3:0] ppos_r;
	logic pbad_r;
	logic req_done_r;
	logic req_bad_r;
	logic [7:0] rq_r [0:15];
	logic [6:0] dst_r;
	logic [6:0] src_r;
	logic [16:0] start_r;
	logic [9:0] cnt_r;
	logic err_r;
	logic [3:0] hpos_r;
	logic [15:0] idx_r;
	logic [9:0] rem_r;
	logic [14:0] tot_r;
	logic first_r;
	logic var_req_r;
	logic [31:0] dig_val_r;
	logic [3:0] dig_pos_r;
	logic [3:0] dig_acc_r;
	logic dig_nch_r;
	logic neg_r;
	logic pwrup_rate_r;
	logic emit_v;
	logic [7:0] emit_b;
	logic fire;
	logic fifo_in_ready;
	logic dst_hit;
	logic req_err;
	logic dig_ge;
	logic [32:0] vm;

	assign vm = mag_of(var_value, var_type);
	assign dst_hit = (dst_r == station_addr);
	assign req_err = req_bad_r || src_r == asr_pkg::ADDR_NONE || src_r > asr_pkg::ADDR_MAX
		|| start_r > asr_pkg::MAX_START
		|| (start_r + 17'(cnt_r)) > 17'(var_total);
	assign dig_ge = dig_val_r >= pow10(dig_pos_r);
	assign fire = emit_v && fifo_in_ready;
	assign var_req = var_req_r;
	assign var_idx = idx_r;
	assign pwrup_rate = pwrup_rate_r;
	assign busy = (state_r != S_IDLE);

	// frame syntax tracking; a caret always restarts
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ppos_r <= '0;
			pbad_r <= 1'b0;
			req_done_r <= 1'b0;
			req_bad_r <= 1'b0;
		end else begin
			req_done_r <= 1'b0;
			if (rx_valid) begin
				if (rx_data == asr_pkg::CH_START) begin
					ppos_r <= asr_pkg::P_DST;
					pbad_r <= 1'b0;
				end else if (ppos_r != '0) begin
					if (rx_data == asr_pkg::CH_END) begin
						req_done_r <= 1'b1;
						req_bad_r <= pbad_r || (ppos_r != asr_pkg::P_END);
						ppos_r <= '0;
					end else if (ppos_r == asr_pkg::P_END) begin
						pbad_r <= 1'b1;
					end else begin
						ppos_r <= ppos_r + 4'h1;
						if (ppos_r == asr_pkg::P_FC ? rx_data != asr_pkg::CH_RD
							: !is_dig(rx_data)) begin
							pbad_r <= 1'b1;
						end
					end
				end
			end
		end
	end

	// field capture and decimal accumulation
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dst_r <= '0;
			src_r <= '0;
			start_r <= '0;
			cnt_r <= '0;
		end else if (rx_valid && ppos_r != '0 && ppos_r != asr_pkg::P_END) begin
			rq_r[ppos_r] <= rx_data;
			if (ppos_r == asr_pkg::P_DST) dst_r <= 7'(rx_data[3:0]);
			else if (ppos_r == asr_pkg::P_DST + 4'h1) dst_r <= 7'(acc10(17'(dst_r), rx_data));
			if (ppos_r == asr_pkg::P_SRC) src_r <= 7'(rx_data[3:0]);
			else if (ppos_r == asr_pkg::P_SRC + 4'h1) src_r <= 7'(acc10(17'(src_r), rx_data));
			if (ppos_r == asr_pkg::P_START) start_r <= 17'(rx_data[3:0]);
			else if (ppos_r > asr_pkg::P_START && ppos_r <= asr_pkg::P_START_LAST)
				start_r <= acc10(start_r, rx_data);
			if (ppos_r == asr_pkg::P_CNT) cnt_r <= 10'(rx_data[3:0]);
			else if (ppos_r > asr_pkg::P_CNT && ppos_r <= asr_pkg::P_CNT_LAST)
				cnt_r <= 10'(acc10(17'(cnt_r), rx_data));
		end
	end

	// byte to emit in each state
	always_comb begin
		emit_v = 1'b0;
		emit_b = asr_pkg::CH_ZERO;
		case (state_r)
			S_HDR: begin
				emit_v = 1'b1;
				case (hpos_r)
					4'h0: emit_b = asr_pkg::CH_START;
					4'h1: emit_b = rq_r[asr_pkg::P_SRC];
					4'h2: emit_b = rq_r[asr_pkg::P_SRC + 4'h1];
					4'h3: emit_b = rq_r[asr_pkg::P_DST];
					4'h4: emit_b = rq_r[asr_pkg::P_DST + 4'h1];
					4'h5: emit_b = err_r ? asr_pkg::CH_ERR : asr_pkg::CH_RD_OK;
					default: emit_b = err_r ? asr_pkg::CH_ZERO : rq_r[hpos_r];
				endcase
			end
			S_SEP: begin
				emit_v = 1'b1;
				emit_b = asr_pkg::CH_SLASH;
			end
			S_SIGN: begin
				emit_v = 1'b1;
				emit_b = asr_pkg::CH_MINUS;
			end
			S_DIG: begin
				emit_v = !dig_ge;
				emit_b = asr_pkg::CH_ZERO + {4'h0, dig_acc_r};
			end
			S_END: begin
				emit_v = 1'b1;
				emit_b = asr_pkg::CH_END;
			end
			default: begin
				emit_v = 1'b0;
			end
		endcase
	end

	// reply sequencing: length pass, header, count, data, end mark
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= S_IDLE;
			err_r <= 1'b0;
			hpos_r <= '0;
			idx_r <= '0;
			rem_r <= '0;
			tot_r <= '0;
			first_r <= 1'b0;
			var_req_r <= 1'b0;
			neg_r <= 1'b0;
		end else begin
			var_req_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					// busy frames are dropped, no queue of requests
					if (req_done_r && dst_hit) begin
						err_r <= req_err;
						idx_r <= start_r[15:0];
						rem_r <= cnt_r;
						tot_r <= '0;
						first_r <= 1'b1;
						hpos_r <= '0;
						state_r <= (req_err || cnt_r == '0) ? S_HDR : S_LEN_REQ;
					end
				end
				// two passes over the table: count must precede the data
				S_LEN_REQ: begin
					var_req_r <= 1'b1;
					state_r <= S_LEN_WAIT;
				end
				S_LEN_WAIT: begin
					if (var_ack) begin
						tot_r <= tot_r + 15'(ndig(vm[31:0])) + 15'(vm[32]) + 15'(!first_r);
						first_r <= 1'b0;
						if (rem_r == 10'h1) begin
							idx_r <= start_r[15:0];
							rem_r <= cnt_r;
							state_r <= S_HDR;
						end else begin
							idx_r <= idx_r + 16'h1;
							rem_r <= rem_r - 10'h1;
							state_r <= S_LEN_REQ;
						end
					end
				end
				S_HDR: begin
					if (fire) begin
						hpos_r <= hpos_r + 4'h1;
						if (hpos_r == asr_pkg::HDR_LAST) begin
							// too long to count in four digits: count goes out as 0000 and no data follow
							if (tot_r > asr_pkg::MAX_CHARS) err_r <= 1'b1;
							first_r <= 1'b1;
							state_r <= S_DIG;
						end
					end
				end
				S_DAT_REQ: begin
					var_req_r <= 1'b1;
					state_r <= S_DAT_WAIT;
				end
				S_DAT_WAIT: begin
					if (var_ack) begin
						neg_r <= vm[32];
						state_r <= !first_r ? S_SEP : (vm[32] ? S_SIGN : S_DIG);
					end
				end
				S_SEP: begin
					if (fire) state_r <= neg_r ? S_SIGN : S_DIG;
				end
				S_SIGN: begin
					if (fire) state_r <= S_DIG;
				end
				S_DIG: begin
					if (fire && dig_pos_r == '0) begin
						if (dig_nch_r) begin
							state_r <= (err_r || rem_r == '0) ? S_END : S_DAT_REQ;
						end else if (rem_r == 10'h1) begin
							state_r <= S_END;
						end else begin
							idx_r <= idx_r + 16'h1;
							rem_r <= rem_r - 10'h1;
							first_r <= 1'b0;
							state_r <= S_DAT_REQ;
						end
					end
				end
				S_END: begin
					if (fire) state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// decimal digits by repeated subtraction of powers of ten
	always_ff @(posedge core_clk) begin
		if (srst) begin
			dig_val_r <= '0;
			dig_pos_r <= '0;
			dig_acc_r <= '0;
			dig_nch_r <= 1'b0;
		end else if (state_r == S_HDR && fire && hpos_r == asr_pkg::HDR_LAST) begin
			// fixed four digits with leading zeros
			dig_val_r <= (err_r || tot_r > asr_pkg::MAX_CHARS) ? '0 : 32'(tot_r);
			dig_pos_r <= asr_pkg::NCH_DIGITS_LAST;
			dig_acc_r <= '0;
			dig_nch_r <= 1'b1;
		end else if (state_r == S_DAT_WAIT && var_ack) begin
			// width from the value itself, so no leading zeros
			dig_val_r <= vm[31:0];
			dig_pos_r <= ndig(vm[31:0]) - 4'h1;
			dig_acc_r <= '0;
			dig_nch_r <= 1'b0;
		end else if (state_r == S_DIG) begin
			if (dig_ge) begin
				dig_val_r <= dig_val_r - pow10(dig_pos_r);
				dig_acc_r <= dig_acc_r + 4'h1;
			end else if (fire) begin
				dig_acc_r <= '0;
				if (dig_pos_r != '0) dig_pos_r <= dig_pos_r - 4'h1;
			end
		end
	end

	// uart holds 9600 baud until the end mark of the first reply enters the tx queue
	always_ff @(posedge core_clk) begin
		if (srst) pwrup_rate_r <= 1'b1;
		else if (state_r == S_END && fire) pwrup_rate_r <= 1'b0;
	end

	asr_fifo #(
		.WIDTH(8),
		.DEPTH(asr_pkg::FIFO_DEPTH)
	) u_txq (
		.core_clk(core_clk),
		.srst(srst),
		.in_valid(emit_v),
		.in_data(emit_b),
		.in_ready(fifo_in_ready),
		.out_valid(tx_valid),
		.out_data(tx_data),
		.out_ready(tx_ready)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_accept;
		state_r == S_IDLE && req_done_r && dst_hit;
	endsequence
	sequence s_fc_out;
		state_r == S_HDR && hpos_r == asr_pkg::P_FC && fire;
	endsequence

	AST_NO_UNSOLICITED: assert property ($rose(busy) |-> $past(req_done_r))
		else $error("reply started without a request");
	AST_FRAME_MARK: assert property (state_r == S_HDR && hpos_r == '0 |-> emit_b == asr_pkg::CH_START)
		else $error("reply does not open with caret");
	AST_END_MARK: assert property (state_r == S_END && fire |=> state_r == S_IDLE
		&& $past(emit_b) == asr_pkg::CH_END)
		else $error("reply does not close with ampersand");
	AST_OK_CODE: assert property (s_fc_out and !err_r |-> emit_b == asr_pkg::CH_RD_OK)
		else $error("good reply lacks r");
	AST_ERR_CODE: assert property (s_accept and req_err |=> err_r ##0 state_r == S_HDR)
		else $error("faulty request not flagged");
	AST_ERR_ZEROS: assert property (state_r == S_HDR && err_r && hpos_r > asr_pkg::P_FC
		|-> emit_b == asr_pkg::CH_ZERO)
		else $error("error header field not zero");
	AST_RANGE: assert property (s_accept and ((start_r + 17'(cnt_r)) > 17'(var_total))
		|=> err_r)
		else $error("out of range request not refused");
	AST_DISCARD: assert property (state_r == S_IDLE && req_done_r && !dst_hit
		|=> state_r == S_IDLE)
		else $error("request for other station answered");
	AST_SWAP: assert property (state_r == S_HDR && hpos_r == 4'h1 |-> emit_b == rq_r[4'h3])
		else $error("reply destination is not request source");
	AST_SEP: assert property (state_r == S_SEP && fire |=> state_r inside {S_SIGN, S_DIG})
		else $error("slash not followed by a value");
	AST_DIGIT: assert property (state_r == S_DIG && fire |-> is_dig(emit_b))
		else $error("non digit emitted in value");
endmodule : asr_slave
